// ===== rtl/t16oc_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - compare counter to value every cycle
// - flag sets on tick after match
// - enabled flag raises irq, service clears
// - writing one clears flag, zero keeps
// - channel a value serves as top
// - double buffer only in pwm modes
// - buffer reloads only at top/bottom
// - software reaches buffer or register by mode
// - value changes only by writes, direct reads
// - high byte held, low write transfers both
// - force strobe acts like a match, in non-pwm modes only
// - force sets no flag, counter untouched
// - counter write blocks next tick's matches
// - counter written to top loses top match
// - output state survives mode changes
// - action field applies at next match
// - pin follows state when steered and active
// - reset clears output state
// - action zero leaves output state alone
// - action sets polarity, never counting
// - action has no effect on capture
// - clear-on-compare action one toggles
// - buffered value copied at top clear, at bottom in pfc modes
module t16oc_top
  import t16oc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // counter side
  input wire logic [15:0] timer_count,
  input wire logic timer_tick,
  input wire logic count_at_top,
  input wire logic count_at_bottom,
  input wire logic count_down,
  input wire logic count_written,
  output logic [15:0] counter_top_value,
  output logic top_match_a,
  output logic [3:0] waveform_mode_select,
  // interrupt requests and service acks
  output logic [1:0] compare_irq,
  input wire logic [1:0] irq_serviced,
  // port pins, a in bit 0, b in bit 1
  input wire logic [1:0] port_value,
  input wire logic [1:0] port_dir,
  output logic [1:0] compare_output_pin,
  output logic [1:0] compare_output_pin_oe
);
  // ==========================================================
  // declarations
  // ==========================================================
  t16oc_ch_if ia ();           // channel a link
  t16oc_ch_if ib ();           // channel b link
  logic [CTRL_W-1:0] ctrl_r;   // control register
  logic [1:0] flag_r;          // compare flags
  logic [7:0] hold_r;          // shared high-byte holding register
  logic blk_r;                 // match blocking after counter write
  logic [1:0] irq_r;           // registered irq lines
  logic [1:0] pin_r;           // registered pin values
  logic [1:0] oe_r;            // registered pin enables
  t16oc_wr_e ws_r;             // write-side state
  logic aw_have_r;             // address captured
  logic w_have_r;              // data captured
  logic [ADDR_W-1:0] awaddr_r; // captured address
  logic [31:0] wdata_r;        // captured data
  logic [3:0] wstrb_r;         // captured strobes
  logic [1:0] bresp_r;         // write answer
  logic rvalid_r;              // read answer pending
  logic [31:0] rdata_r;        // read data
  logic [1:0] rresp_r;         // read answer
  logic wr_fire;               // one-cycle write commit
  logic wr_ok;                 // committed address is mapped
  logic [31:0] rd_mux;         // read data before the flop
  logic rd_ok;                 // read address is mapped
  logic [3:0] mode;            // waveform mode field
  logic [1:0] act_a;           // action field a
  logic [1:0] act_b;           // action field b
  logic [1:0] steer;           // pin steer bits
  logic [1:0] irq_en;          // irq enable bits
  logic [1:0] hits;            // qualified matches
  logic [1:0] ostates;         // output states
  logic [1:0] flag_clr;        // software and service clears
  logic upd_pt;                // reload point for this mode

  // ==========================================================
  // control field split
  // ==========================================================
  assign mode = ctrl_r[CTRL_MODE_LSB +: 4];
  assign act_a = ctrl_r[CTRL_ACTA_LSB +: 2];
  assign act_b = ctrl_r[CTRL_ACTB_LSB +: 2];
  assign steer = ctrl_r[CTRL_STEER_LSB +: 2];
  assign irq_en = ctrl_r[CTRL_IRQEN_LSB +: 2];
  assign waveform_mode_select = mode;
  // dual-slope pfc modes reload at bottom, all others at top
  assign upd_pt = mode_upd_bottom(mode) ? count_at_bottom : count_at_top;

  // ==========================================================
  // write channel: address and data in either order
  // ==========================================================
  assign awready = (ws_r == WS_COLLECT) && !aw_have_r;
  assign wready = (ws_r == WS_COLLECT) && !w_have_r;
  assign wr_fire = (ws_r == WS_COLLECT) && aw_have_r && w_have_r;
  assign wr_ok = (awaddr_r == OFS_CTRL) || (awaddr_r == OFS_FLAG)
              || (awaddr_r == OFS_FORCE) || (awaddr_r == OFS_CA_HI)
              || (awaddr_r == OFS_CA_LO) || (awaddr_r == OFS_CB_HI)
              || (awaddr_r == OFS_CB_LO) || (awaddr_r == OFS_STAT);

  // capture address and data; protection bits are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= {awaddr[ADDR_W-1:2], 2'b00};
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // response state, answer one cycle after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_r <= WS_COLLECT;
      bresp_r <= RESP_OKAY;
    end else begin
      case (ws_r)
        WS_COLLECT: begin
          if (wr_fire) begin
            ws_r <= WS_RESP;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WS_RESP: begin
          if (bready) begin
            ws_r <= WS_COLLECT;
          end
        end
        default: ws_r <= WS_COLLECT;
      endcase
    end
  end
  assign bvalid = (ws_r == WS_RESP);
  assign bresp = bresp_r;

  // ==========================================================
  // register writes
  // ==========================================================
  // action bits are live: no buffering, next match uses them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_fire && awaddr_r == OFS_CTRL) begin
      if (wstrb_r[0]) begin
        ctrl_r[7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        ctrl_r[CTRL_W-1:8] <= wdata_r[CTRL_W-1:8];
      end
    end
  end

  // one holding register shared by both high bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= HOLD_RST;
    end else if (wr_fire && wstrb_r[0]
                 && (awaddr_r == OFS_CA_HI || awaddr_r == OFS_CB_HI)) begin
      hold_r <= wdata_r[7:0];
    end
  end

  // ==========================================================
  // flags and interrupts
  // ==========================================================
  assign hits = {ib.hit, ia.hit};
  assign flag_clr = irq_serviced
                  | ({2{wr_fire && wstrb_r[0] && awaddr_r == OFS_FLAG}} & wdata_r[1:0]);

  // a set in the clearing cycle wins; force never reaches here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 2'b00;
    end else begin
      flag_r <= (flag_r & ~flag_clr) | hits;
    end
  end

  // irq is a registered level, one cycle behind the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 2'b00;
    end else begin
      irq_r <= flag_r & irq_en;
    end
  end
  assign compare_irq = irq_r;

  // ==========================================================
  // match blocking after a counter write
  // ==========================================================
  // held until the next tick, so a stopped timer still blocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_r <= 1'b0;
    end else if (count_written) begin
      blk_r <= 1'b1;
    end else if (timer_tick) begin
      blk_r <= 1'b0;
    end
  end

  // ==========================================================
  // channel links; only a feeds the counter
  // ==========================================================
  assign ia.count = timer_count;
  assign ia.tick = timer_tick;
  assign ia.blocked = blk_r;
  assign ia.pwm = mode_is_pwm(mode);
  assign ia.fast = mode_is_fast(mode);
  assign ia.down = count_down;
  assign ia.upd_pt = upd_pt;
  assign ia.at_top = count_at_top;
  assign ia.action = act_a;
  assign ia.force_stb = wr_fire && wstrb_r[0] && awaddr_r == OFS_FORCE && wdata_r[0];
  assign ia.wr_en = wr_fire && wstrb_r[0] && awaddr_r == OFS_CA_LO;
  assign ia.wr_data = {hold_r, wdata_r[7:0]};

  assign ib.count = timer_count;
  assign ib.tick = timer_tick;
  assign ib.blocked = blk_r;
  assign ib.pwm = mode_is_pwm(mode);
  assign ib.fast = mode_is_fast(mode);
  assign ib.down = count_down;
  assign ib.upd_pt = upd_pt;
  assign ib.at_top = count_at_top;
  assign ib.action = act_b;
  assign ib.force_stb = wr_fire && wstrb_r[0] && awaddr_r == OFS_FORCE && wdata_r[1];
  assign ib.wr_en = wr_fire && wstrb_r[0] && awaddr_r == OFS_CB_LO;
  assign ib.wr_data = {hold_r, wdata_r[7:0]};

  t16oc_chan u_chan_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch(ia.chan)
  );
  t16oc_chan u_chan_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch(ib.chan)
  );

  // counter sees value and match of a; action bits have no path
  // to the counter or to capture logic
  assign counter_top_value = ia.cmp;
  assign top_match_a = ia.hit;
  assign ostates = {ib.ostate, ia.ostate};

  // ==========================================================
  // pin override
  // ==========================================================
  // registered so the pin never glitches on an action change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 2'b00;
      oe_r <= 2'b00;
    end else begin
      pin_r[0] <= (act_a != ACT_NONE && steer[0]) ? ostates[0] : port_value[0];
      pin_r[1] <= (act_b != ACT_NONE && steer[1]) ? ostates[1] : port_value[1];
      oe_r <= port_dir;
    end
  end
  assign compare_output_pin = pin_r;
  assign compare_output_pin_oe = oe_r;

  // ==========================================================
  // read channel
  // ==========================================================
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (araddr & {{(ADDR_W-2){1'b1}}, 2'b00})
      OFS_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
      OFS_FLAG: rd_mux[1:0] = flag_r;
      OFS_FORCE: rd_mux = 32'h0000_0000;
      OFS_CA_HI: rd_mux[7:0] = ia.cpu_view[15:8];
      OFS_CA_LO: rd_mux[7:0] = ia.cpu_view[7:0];
      OFS_CB_HI: rd_mux[7:0] = ib.cpu_view[15:8];
      OFS_CB_LO: rd_mux[7:0] = ib.cpu_view[7:0];
      OFS_STAT: rd_mux[1:0] = ostates;
      default: rd_ok = 1'b0;
    endcase
  end

  assign arready = !rvalid_r;
  // reads have no side effects; answer one cycle after accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ==========================================================
  // checks
  // ==========================================================
  a_flag_on_match: assert property (@(posedge aclk) disable iff (!aresetn)
    ia.hit |=> flag_r[0])
    else $error("flag a not set after match");
  a_flag_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wstrb_r[0] && awaddr_r == OFS_FLAG && wdata_r[1] && !ib.hit
    |=> !flag_r[1])
    else $error("flag b not cleared by write of one");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_r[0] && irq_en[0] |=> compare_irq[0])
    else $error("enabled flag a gave no interrupt");
  a_block_after_wr: assert property (@(posedge aclk) disable iff (!aresetn)
    count_written |=> !ia.hit && !ib.hit)
    else $error("match not blocked after counter write");
  a_hold_transfer: assert property (@(posedge aclk) disable iff (!aresetn)
    ia.wr_en && !ia.pwm |=> ia.cmp == {$past(hold_r), $past(wdata_r[7:0])})
    else $error("16-bit write to a not assembled from held byte");
  a_force_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ib.force_stb && !flag_r[1] && !ib.hit |=> !flag_r[1])
    else $error("forced compare set a flag");
  a_pin_steer: assert property (@(posedge aclk) disable iff (!aresetn)
    act_a != ACT_NONE && steer[0] |=> compare_output_pin[0] == $past(ostates[0]))
    else $error("pin a not steered from output state");
endmodule : t16oc_top

// ===== rtl/t16oc_pkg.sv
// ==========================================================
// constants for the 16-bit output compare block
// ==========================================================
package t16oc_pkg;
  // register map, byte addresses on the lite bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CA_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CA_LO = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CB_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CB_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h1c;
  // control register layout
  localparam int CTRL_W = 12;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_STEER_LSB = 8;
  localparam int CTRL_IRQEN_LSB = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] HOLD_RST = 8'h00;
  // waveform modes named here; the rest are pwm
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] MODE_CTC_CAP = 4'hc;
  localparam logic [3:0] MODE_RSVD = 4'hd;
  localparam logic [3:0] MODE_FAST_8 = 4'h5;
  localparam logic [3:0] MODE_FAST_9 = 4'h6;
  localparam logic [3:0] MODE_FAST_10 = 4'h7;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_CMP = 4'hf;
  // output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // write-side bus states, one-hot
  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP = 2'b10
  } t16oc_wr_e;

  // twelve pwm modes; reserved code behaves as non-pwm
  function automatic logic mode_is_pwm(input logic [3:0] m);
    mode_is_pwm = !(m == MODE_NORMAL || m == MODE_CTC_CMP || m == MODE_CTC_CAP
                    || m == MODE_RSVD);
  endfunction : mode_is_pwm

  // single-slope modes
  function automatic logic mode_is_fast(input logic [3:0] m);
    mode_is_fast = (m == MODE_FAST_8 || m == MODE_FAST_9 || m == MODE_FAST_10
                    || m == MODE_FAST_CAP || m == MODE_FAST_CMP);
  endfunction : mode_is_fast

  // phase and frequency correct modes reload at bottom
  function automatic logic mode_upd_bottom(input logic [3:0] m);
    mode_upd_bottom = (m == MODE_PFC_CAP || m == MODE_PFC_CMP);
  endfunction : mode_upd_bottom
endpackage : t16oc_pkg

// ===== rtl/t16oc_ch_if.sv
`timescale 1ns/100ps
// ==========================================================
// link between the top and one compare channel
// ==========================================================
interface t16oc_ch_if;
  logic [15:0] count;   // live counter value
  logic tick;           // timer clock tick
  logic blocked;        // matches suppressed this cycle
  logic pwm;            // a pwm mode is selected
  logic fast;           // single-slope pwm
  logic down;           // counter is counting down
  logic upd_pt;         // top or bottom reload point
  logic at_top;         // counter at top
  logic [1:0] action;   // output action field
  logic force_stb;      // force strobe pulse
  logic wr_en;          // full 16-bit write pulse
  logic [15:0] wr_data; // assembled write data
  logic [15:0] cpu_view; // what software reads
  logic [15:0] cmp;     // active compare value
  logic hit;            // qualified match on a tick
  logic ostate;         // output state bit

  modport ctl (
    output count, tick, blocked, pwm, fast, down, upd_pt, at_top, action,
    output force_stb, wr_en, wr_data,
    input cpu_view, cmp, hit, ostate
  );
  modport chan (
    input count, tick, blocked, pwm, fast, down, upd_pt, at_top, action,
    input force_stb, wr_en, wr_data,
    output cpu_view, cmp, hit, ostate
  );
endinterface : t16oc_ch_if

// ===== rtl/t16oc_chan.sv
`timescale 1ns/100ps
// ==========================================================
// one compare channel: registers, comparator, output state
// ==========================================================
module t16oc_chan
  import t16oc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  t16oc_ch_if.chan ch
);
  logic [15:0] buf_r; // double buffer
  logic [15:0] cmp_r; // compare register
  logic ost_r;        // output state bit
  logic eq;           // raw equality

  // ==========================================================
  // compare value storage
  // ==========================================================
  // buffer only takes writes while a pwm mode is selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_r <= CMP_RST;
    end else if (ch.wr_en && ch.pwm) begin
      buf_r <= ch.wr_data;
    end
  end

  // direct writes outside pwm, reload at the sync point inside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_r <= CMP_RST;
    end else if (ch.wr_en && !ch.pwm) begin
      cmp_r <= ch.wr_data;
    end else if (ch.pwm && ch.tick && ch.upd_pt) begin
      cmp_r <= buf_r;
    end
  end

  // software sees the register it writes, no holding register
  assign ch.cpu_view = ch.pwm ? buf_r : cmp_r;
  assign ch.cmp = cmp_r;

  // ==========================================================
  // comparator
  // ==========================================================
  assign eq = (ch.count == cmp_r);
  // a match takes effect on the next tick unless blocked
  assign ch.hit = ch.tick && eq && !ch.blocked;

  // ==========================================================
  // output state; mode changes never touch it
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ost_r <= 1'b0;
    end else if (ch.force_stb && !ch.pwm) begin
      case (ch.action)
        ACT_TOGGLE: ost_r <= !ost_r;
        ACT_CLEAR: ost_r <= 1'b0;
        ACT_SET: ost_r <= 1'b1;
        default: ost_r <= ost_r;
      endcase
    end else if (ch.pwm && ch.fast && ch.tick && ch.at_top && !ch.hit) begin
      // single slope: restore level at top
      case (ch.action)
        ACT_CLEAR: ost_r <= 1'b0;
        ACT_SET: ost_r <= 1'b1;
        default: ost_r <= ost_r;
      endcase
    end else if (ch.hit && !ch.pwm) begin
      case (ch.action)
        ACT_TOGGLE: ost_r <= !ost_r;
        ACT_CLEAR: ost_r <= 1'b0;
        ACT_SET: ost_r <= 1'b1;
        default: ost_r <= ost_r;
      endcase
    end else if (ch.hit) begin
      // pwm: polarity only; toggle code reserved here
      case (ch.action)
        ACT_CLEAR: ost_r <= ch.fast ? 1'b1 : ch.down;
        ACT_SET: ost_r <= ch.fast ? 1'b0 : !ch.down;
        default: ost_r <= ost_r;
      endcase
    end
  end
  assign ch.ostate = ost_r;

  // ==========================================================
  // checks
  // ==========================================================
  a_buf_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    ch.pwm && ch.tick && ch.upd_pt && !ch.wr_en |=> cmp_r == $past(buf_r))
    else $error("compare register missed its reload");
  a_none_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
    ch.action == ACT_NONE |=> ost_r == $past(ost_r))
    else $error("output state moved with no action selected");
  a_toggle_on_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    ch.hit && !ch.pwm && ch.action == ACT_TOGGLE |=> ost_r != $past(ost_r))
    else $error("toggle action did not toggle");
endmodule : t16oc_chan

// ===== sim/t16oc_cnt_model.sv
`timescale 1ns/100ps
// ====
// counter stand-in, ticks every other cycle while run
// ====
module t16oc_cnt_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [15:0] top,
  input wire logic top_hit,
  // counter side
  output logic [15:0] timer_count,
  output logic timer_tick,
  output logic count_at_top,
  output logic count_at_bottom
);
  assign count_at_top = (timer_count == top);
  assign count_at_bottom = (timer_count == 16'h0000);
  // clear on a taken top match or a tick at top, so a blocked one is lost in ctc mode only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= 16'h0000;
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= run & ~timer_tick;
      if (top_hit || (timer_tick && count_at_top)) timer_count <= 16'h0000;
      else if (timer_tick) timer_count <= timer_count + 16'h0001;
    end
  end
endmodule : t16oc_cnt_model

// ===== sim/tb_top.sv
`timescale 1ns/100ps
// ====
// bench: lite-bus calls with expected values
// ====
module tb_top
  import t16oc_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic run = 0, count_down = 0, count_written = 0, awready, wready, bvalid, arready, rvalid;
  logic top_match_a, timer_tick, count_at_top, count_at_bottom;
  logic [ADDR_W-1:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic [3:0] wstrb = 4'hf, waveform_mode_select;
  logic [2:0] awprot = 0, arprot = 0;
  logic [1:0] irq_serviced = 0, port_value = 0, port_dir = 2'h3, bresp, rresp, rr, rb;
  logic [1:0] compare_irq, compare_output_pin, compare_output_pin_oe;
  logic [15:0] counter_top_value, timer_count;
  int checks = 0, mismatches = 0;
  always #2 aclk = ~aclk;
  t16oc_top uut (.*);
  t16oc_cnt_model cnt (.aclk(aclk), .aresetn(aresetn), .run(run),
    .top(waveform_mode_select == MODE_FAST_CMP ? counter_top_value : 16'hffff),
    .top_hit(top_match_a & (waveform_mode_select inside {MODE_CTC_CMP, MODE_FAST_CMP})),
    .timer_count(timer_count), .timer_tick(timer_tick), .count_at_top(count_at_top),
    .count_at_bottom(count_at_bottom));
  // compare and report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // bready held from the start; halves released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ga, gw, gb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ga = awvalid & awready;
      gw = wvalid & wready;
      gb = bvalid;
      rb = bresp;
      @(posedge aclk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end while (!gb);
    bready <= 1'b0;
    // let an edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask : wr
  // read and compare the data word
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic ga, gb;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ga = arvalid & arready;
      gb = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ga) arvalid <= 1'b0;
    end while (!gb);
    rready <= 1'b0;
    @(posedge aclk);
    chk(n, e, rv);
  endtask : rdc
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc("stat", OFS_STAT, 0);
    rdc("unmapped", 8'hfc, 0);
    chk("rresp", RESP_SLVERR, rr);
    wr(8'hfc, 0);
    chk("bresp", RESP_SLVERR, rb);
    wr(OFS_CA_HI, 0);
    wr(OFS_CA_LO, 32'h10);
    chk("bresp ok", RESP_OKAY, rb);
    rdc("ca lo", OFS_CA_LO, 32'h10);
    chk("top", 16'h10, counter_top_value);
    $display("test bus done");
    // clear-on-compare, toggle, steer a, irq a
    wr(OFS_CTRL, 32'h514);
    // counter written at zero: the first tick must not match b
    count_written <= 1'b1;
    @(posedge aclk);
    count_written <= 1'b0;
    run <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc("flag blocked", OFS_FLAG, 0);
    for (int n = 0; n < 200 && compare_irq[0] !== 1'b1; n++) @(posedge aclk);
    run <= 1'b0;
    chk("irq a", 1, compare_irq[0]);
    rdc("flag", OFS_FLAG, 3);
    irq_serviced <= 2'b01;
    @(posedge aclk);
    irq_serviced <= 2'b00;
    rdc("flag svc", OFS_FLAG, 2);
    wr(OFS_FLAG, 0);
    rdc("flag w0", OFS_FLAG, 2);
    wr(OFS_FLAG, 2);
    rdc("flag w1", OFS_FLAG, 0);
    chk("irq", 0, compare_irq);
    rdc("stat toggle", OFS_STAT, 1);
    $display("test flags done");
    // force a clear, then a set, in normal mode, counter stopped
    wr(OFS_CTRL, 32'h120);
    port_value <= 2'b10;
    port_dir <= 2'b01;
    wr(OFS_FORCE, 1);
    rdc("stat clear", OFS_STAT, 0);
    chk("pins clear", 2'b10, compare_output_pin);
    chk("oe", 2'b01, compare_output_pin_oe);
    wr(OFS_CTRL, 32'h130);
    wr(OFS_FORCE, 1);
    rdc("stat force", OFS_STAT, 1);
    rdc("flag force", OFS_FLAG, 0);
    chk("pins", 2'b11, compare_output_pin);
    // fast pwm, top from a, buffered
    wr(OFS_CTRL, 32'h13f);
    rdc("stat mode", OFS_STAT, 1);
    wr(OFS_CA_HI, 0);
    wr(OFS_CA_LO, 32'h20);
    rdc("ca buf", OFS_CA_LO, 32'h20);
    chk("top held", 16'h10, counter_top_value);
    run <= 1'b1;
    for (int n = 0; n < 600 && counter_top_value !== 16'h20; n++) @(posedge aclk);
    chk("top load", 16'h20, counter_top_value);
    $display("test force and buffer done");
    close_out();
  end
endmodule : tb_top
